// >>> verilog/crb_pkg.sv
// Purpose: shared constants for the core register and branch logic
// Assumes: 14-bit instruction words, 7-bit file addresses, 13-bit program counter
// Notes: special register addresses select hardware state instead of plain file storage
`default_nettype none
package crb_pkg;
    // Special register file addresses
    localparam logic [6:0] ADDR_PC_LOW = 7'h02;
    localparam logic [6:0] ADDR_STATUS = 7'h03;
    localparam logic [6:0] ADDR_PIN_DIR = 7'h06;
    localparam logic [6:0] ADDR_PC_LATCH = 7'h0a;

    // Status bit positions
    localparam int STAT_C = 0;
    localparam int STAT_DIGIT_CARRY = 1;
    localparam int STAT_Z = 2;

    // Reset values
    localparam logic [7:0] STATUS_RST = 8'h18;
    localparam logic [7:0] PIN_DIR_RST = 8'hff;
    localparam logic [12:0] PC_RST = 13'h0000;
    localparam logic [4:0] PC_LATCH_RST = 5'h00;
    localparam logic [7:0] WORK_RST = 8'h00;
    localparam logic [7:0] FILE_RST = 8'h00;

    // Bit of the pin direction register tied high (input-only pin)
    localparam logic [7:0] PIN_DIR_FORCED = 8'h08;

    // Program counter steps
    localparam logic [12:0] PC_STEP = 13'h0001;
    localparam logic [12:0] PC_SKIP_STEP = 13'h0002;

    // Opcode fields
    localparam logic [2:0] OPC_JUMP = 3'h5;
    localparam logic [5:0] OPC_INC_SKIP = 6'h0f;
    localparam logic [5:0] OPC_INCF = 6'h0a;
    localparam logic [5:0] OPC_ADDWF = 6'h07;
    localparam logic [5:0] OPC_MOVF = 6'h08;
    localparam logic [6:0] OPC_CLRF = 7'h03;
    localparam logic [6:0] OPC_MOVWF = 7'h01;
    localparam logic [3:0] OPC_BCF = 4'h4;
    localparam logic [3:0] OPC_BSF = 4'h5;

    typedef enum logic [1:0] {
        ST_EXEC = 2'b01,
        ST_FLUSH = 2'b10
    } crb_state_e;
endpackage
`default_nettype wire

// >>> verilog/crb_core.sv
// Purpose: instruction execution for file register access, jump and increment-skip
// Assumes: instr holds the word fetched at address pc, same clock, no synchroniser
// Notes: unlisted opcodes execute as no-operation
`timescale 1ns/1ns
`default_nettype none
module crb_core (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [13:0] instr,
    input wire logic instr_valid,
    output logic [12:0] pc,
    output logic discard,
    output logic [7:0] working_reg,
    output logic [7:0] status_reg,
    output logic [4:0] pc_high_holding_latch,
    output logic [7:0] pin_direction_reg
);
    crb_pkg::crb_state_e state;
    crb_pkg::crb_state_e next_state;
    logic [12:0] next_pc;
    logic [7:0] next_working_reg;
    logic [7:0] next_status_reg;
    logic [4:0] next_pc_high_holding_latch;
    logic [7:0] next_pin_direction_reg;
    logic [7:0] file_mem [128];
    logic next_mem_we;
    logic [6:0] next_mem_addr;
    logic [7:0] next_mem_wdata;

    // Decode scratch
    logic [6:0] faddr;
    logic dest_file;
    logic [7:0] fval;
    logic [7:0] result;
    logic [8:0] sum9;
    logic [4:0] sum5;
    logic do_write;
    logic upd_z;
    logic upd_cdc;
    logic new_c;
    logic new_dc;
    logic skip;

    always_comb begin
        next_state = state;
        next_pc = pc;
        next_working_reg = working_reg;
        next_status_reg = status_reg;
        next_pc_high_holding_latch = pc_high_holding_latch;
        next_pin_direction_reg = pin_direction_reg;
        next_mem_we = 1'b0;
        next_mem_addr = instr[6:0];
        next_mem_wdata = 8'h00;
        faddr = instr[6:0];
        dest_file = instr[7];
        result = 8'h00;
        sum9 = 9'h000;
        sum5 = 5'h00;
        do_write = 1'b0;
        upd_z = 1'b0;
        upd_cdc = 1'b0;
        new_c = 1'b0;
        new_dc = 1'b0;
        skip = 1'b0;
        // Source operand: special addresses map onto live hardware state
        case (faddr)
            // pc low read
            // Pc is the address of the word executing now, not the next fetch,
            // so a computed branch built from this read lands where software expects
            crb_pkg::ADDR_PC_LOW: fval = pc[7:0];
            crb_pkg::ADDR_STATUS: fval = status_reg;
            // Upper latch bits do not exist and read as zero
            crb_pkg::ADDR_PC_LATCH: fval = {3'h0, pc_high_holding_latch};
            crb_pkg::ADDR_PIN_DIR: fval = pin_direction_reg | crb_pkg::PIN_DIR_FORCED;
            default: fval = file_mem[faddr];
        endcase
        if (instr_valid) begin
            if (state == crb_pkg::ST_FLUSH) begin
                // discarded slot as nop
                // Pc already points at the target, so it is held here
                next_state = crb_pkg::ST_EXEC;
            end else begin
                next_pc = pc + crb_pkg::PC_STEP;
                if (instr[13:11] == crb_pkg::OPC_JUMP) begin
                    next_pc = {pc_high_holding_latch[4:3], instr[10:0]};
                    next_state = crb_pkg::ST_FLUSH;
                // Jump is tested first: its 3-bit prefix never overlaps the other opcodes
                end else if (instr[13:8] == crb_pkg::OPC_INC_SKIP) begin
                    result = fval + 8'h01;
                    do_write = 1'b1;
                    if (result == 8'h00) begin
                        skip = 1'b1;
                    end
                end else if (instr[13:8] == crb_pkg::OPC_INCF) begin
                    result = fval + 8'h01;
                    do_write = 1'b1;
                    upd_z = 1'b1;
                end else if (instr[13:8] == crb_pkg::OPC_ADDWF) begin
                    sum9 = {1'b0, fval} + {1'b0, working_reg};
                    sum5 = {1'b0, fval[3:0]} + {1'b0, working_reg[3:0]};
                    result = sum9[7:0];
                    new_c = sum9[8];
                    new_dc = sum5[4];
                    do_write = 1'b1;
                    upd_z = 1'b1;
                    upd_cdc = 1'b1;
                end else if (instr[13:8] == crb_pkg::OPC_MOVF) begin
                    result = fval;
                    do_write = 1'b1;
                    upd_z = 1'b1;
                end else if (instr[13:7] == crb_pkg::OPC_CLRF) begin
                    result = 8'h00;
                    dest_file = 1'b1;
                    do_write = 1'b1;
                    upd_z = 1'b1;
                end else if (instr[13:7] == crb_pkg::OPC_MOVWF) begin
                    result = working_reg;
                    dest_file = 1'b1;
                    do_write = 1'b1;
                end else if (instr[13:10] == crb_pkg::OPC_BCF) begin
                    result = fval & ~(8'h01 << instr[9:7]);
                    dest_file = 1'b1;
                    do_write = 1'b1;
                end else if (instr[13:10] == crb_pkg::OPC_BSF) begin
                    result = fval | (8'h01 << instr[9:7]);
                    dest_file = 1'b1;
                    do_write = 1'b1;
                end
                if (do_write && !dest_file) begin
                    next_working_reg = result;
                end else if (do_write) begin
                    case (faddr)
                        // Reads of pc low above feed the ALU first, so a
                        // read-modify-write of pc low uses the current address
                        crb_pkg::ADDR_PC_LOW: begin
                            // latch into high byte, result into low byte
                            next_pc = {pc_high_holding_latch, result};
                            // Stale prefetch must not run after a computed branch
                            next_state = crb_pkg::ST_FLUSH;
                        end
                        crb_pkg::ADDR_STATUS: next_status_reg = result;
                        // Latch is only five bits wide; the top three are dropped
                        crb_pkg::ADDR_PC_LATCH: next_pc_high_holding_latch = result[4:0];
                        crb_pkg::ADDR_PIN_DIR: begin
                            next_pin_direction_reg = result | crb_pkg::PIN_DIR_FORCED;
                        end
                        default: begin
                            next_mem_we = 1'b1;
                            next_mem_wdata = result;
                        end
                    endcase
                end
                if (skip) begin
                    next_pc = pc + crb_pkg::PC_SKIP_STEP;
                    next_state = crb_pkg::ST_FLUSH;
                end
                // flags override the written status value
                if (upd_z) begin
                    next_status_reg[crb_pkg::STAT_Z] = (result == 8'h00);
                end
                if (upd_cdc) begin
                    next_status_reg[crb_pkg::STAT_C] = new_c;
                    next_status_reg[crb_pkg::STAT_DIGIT_CARRY] = new_dc;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= crb_pkg::ST_EXEC;
            pc <= crb_pkg::PC_RST;
            working_reg <= crb_pkg::WORK_RST;
            status_reg <= crb_pkg::STATUS_RST;
            pc_high_holding_latch <= crb_pkg::PC_LATCH_RST;
            pin_direction_reg <= crb_pkg::PIN_DIR_RST;
            discard <= 1'b0;
        end else begin
            state <= next_state;
            pc <= next_pc;
            working_reg <= next_working_reg;
            status_reg <= next_status_reg;
            pc_high_holding_latch <= next_pc_high_holding_latch;
            pin_direction_reg <= next_pin_direction_reg;
            // Registered copy of the flush state so the fetcher sees it from a flop
            discard <= (next_state == crb_pkg::ST_FLUSH);
        end
    end

    // General file storage, one flop byte per address
    // Special addresses also get a byte here that is never written; the cost
    // of the unused flops was traded for a uniform generate loop
    for (genvar i = 0; i < 128; i++) begin : g_file
        always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
                file_mem[i] <= crb_pkg::FILE_RST;
            end else if (next_mem_we && (next_mem_addr == 7'(i))) begin
                file_mem[i] <= next_mem_wdata;
            end
        end
    end
endmodule // crb_core
`default_nettype wire

// >>> bench/crb_core_asserts.sv
// Purpose: port-level checks for the core register and branch logic
// Assumes: one clock, asynchronous active-low reset
// Notes: bound to the core from the testbench top file
`timescale 1ns/1ns
`default_nettype none
module crb_core_asserts (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [13:0] instr,
    input wire logic instr_valid,
    input wire logic [12:0] pc,
    input wire logic discard,
    input wire logic [7:0] working_reg,
    input wire logic [7:0] status_reg,
    input wire logic [4:0] pc_high_holding_latch,
    input wire logic [7:0] pin_direction_reg
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // A word that really executes, not one thrown away in a flush slot
    wire ex = instr_valid && !discard;
    wire jmp = ex && instr[13:11] == crb_pkg::OPC_JUMP;
    a_dir_bit_high: assert property (pin_direction_reg[3])
        else $error("direction bit 3 low");
    a_jump_target: assert property (jmp |=> discard &&
        pc == {$past(pc_high_holding_latch[4:3]), $past(instr[10:0])}) else $error("jump pc");
    a_jump_flags: assert property (jmp |=> $stable(status_reg))
        else $error("jump changed status");
    a_flush_slot: assert property (instr_valid && discard |=> !discard && $stable(pc))
        else $error("flush slot not honoured");
    a_skip_result: assert property (ex && instr[13:7] == {crb_pkg::OPC_INC_SKIP, 1'b0} |=>
        $stable(status_reg) && discard == (working_reg == 8'h00) &&
        pc == $past(pc) + (discard ? 13'h0002 : 13'h0001)) else $error("skip result");
    a_idle_hold: assert property (!instr_valid |=> $stable(pc) && $stable(discard) &&
        $stable(working_reg) && $stable(status_reg)) else $error("idle cycle changed state");
    a_pc_low_write: assert property (ex &&
        instr == {crb_pkg::OPC_MOVWF, crb_pkg::ADDR_PC_LOW} |=>
        discard && pc == {$past(pc_high_holding_latch), $past(working_reg)})
        else $error("pc low write");
    a_status_clear: assert property (ex &&
        instr == {crb_pkg::OPC_CLRF, crb_pkg::ADDR_STATUS} |=> status_reg == 8'h04)
        else $error("status clear flags");
    a_pc_read: assert property (ex &&
        instr == {crb_pkg::OPC_MOVF, 1'b0, crb_pkg::ADDR_PC_LOW} |=> working_reg == $past(pc[7:0]))
        else $error("pc low read");
endmodule // crb_core_asserts
`default_nettype wire

// >>> bench/test_crb_core.sv
// Purpose: self-checking bench for the core register and branch logic
// Assumes: bench acts as fetcher and presents one word per step
// Notes: W is loaded by clearing a scratch byte and setting its bits
`timescale 1ns/1ns
`default_nettype none
module test_crb_core;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [13:0] instr = 14'h0000;
    logic instr_valid = 1'b0;
    logic [12:0] pc, p;
    logic discard;
    logic [7:0] working_reg, status_reg, pin_direction_reg, v, w;
    logic [4:0] pc_high_holding_latch;
    logic [10:0] k;
    logic [2:0] b;
    int bad_count = 0;
    int check_count = 0;
    int seed = 32'hffaa244a;
    crb_core DUT (.clk(clk), .resetn(resetn), .instr(instr), .instr_valid(instr_valid),
        .pc(pc), .discard(discard), .working_reg(working_reg), .status_reg(status_reg),
        .pc_high_holding_latch(pc_high_holding_latch), .pin_direction_reg(pin_direction_reg));
    always #25 clk = ~clk;
    function automatic logic [7:0] add_status(input logic [7:0] a, input logic [7:0] x);
        logic [8:0] s;
        s = a + x;
        return {s[7:3], s[7:0] == 8'h00, (a[3:0] + x[3:0]) > 5'h0f, s[8]};
    endfunction
    task chk(input logic [12:0] got, input logic [12:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Valid stays high between steps so no signal is driven twice in one time step
    task step(input logic [13:0] x);
        instr = x;
        instr_valid = 1'b1;
        @(posedge clk);
        #1;
    endtask
    task idle();
        instr = 14'($random(seed));
        instr_valid = 1'b0;
        @(posedge clk);
        #1;
    endtask
    task load_w(input logic [7:0] x);
        step({crb_pkg::OPC_CLRF, 7'h20});
        for (int i = 0; i < 8; i++)
            if (x[i]) step({crb_pkg::OPC_BSF, 3'(i), 7'h20});
        step({crb_pkg::OPC_MOVF, 1'b0, 7'h20});
    endtask
    task summarize();
        $display("checks %0d, mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #1000000;
        bad_count++;
        summarize();
    end
    initial begin
        repeat (6) @(posedge clk);
        #1;
        resetn = 1'b1;
        chk(pin_direction_reg, 8'hff);
        load_w(8'h00);
        step({crb_pkg::OPC_MOVWF, crb_pkg::ADDR_PIN_DIR});
        chk(pin_direction_reg, 8'h08);
        step({crb_pkg::OPC_BCF, 3'h3, crb_pkg::ADDR_PIN_DIR});
        step({crb_pkg::OPC_BSF, 3'h0, crb_pkg::ADDR_PIN_DIR});
        chk(pin_direction_reg, 8'h09);
        repeat (6) begin
            v = 8'($random(seed));
            b = 3'($random(seed));
            load_w(v);
            step({crb_pkg::OPC_BCF, b, 7'h20});
            idle();
            step({crb_pkg::OPC_MOVF, 1'b0, 7'h20});
            chk(working_reg, v & ~(8'h01 << b));
        end
        repeat (5) begin
            v = 8'($random(seed));
            w = 8'($random(seed));
            load_w(v);
            step({crb_pkg::OPC_MOVWF, crb_pkg::ADDR_STATUS});
            load_w(w);
            step({crb_pkg::OPC_ADDWF, 1'b1, crb_pkg::ADDR_STATUS});
            chk(status_reg, add_status({v[7:3], w == 8'h00, v[1:0]}, w));
        end
        step({crb_pkg::OPC_CLRF, crb_pkg::ADDR_STATUS});
        chk(status_reg, 8'h04);
        for (int i = 0; i < 6; i++) begin
            v = 8'($random(seed));
            k = (i == 0) ? 11'h7ff : (i == 1) ? 11'h000 : 11'($random(seed));
            p = {v[4:3], k};
            load_w(v);
            step({crb_pkg::OPC_MOVWF, crb_pkg::ADDR_PC_LATCH});
            chk(pc_high_holding_latch, v[4:0]);
            step({crb_pkg::OPC_JUMP, k});
            chk(pc, p);
            chk(discard, 1'b1);
            idle();
            step(14'h3fff);
            chk(pc, p);
            step({crb_pkg::OPC_MOVF, 1'b0, crb_pkg::ADDR_PC_LOW});
            chk(working_reg, k[7:0]);
            load_w(8'hff);
            step({crb_pkg::OPC_MOVWF, 7'h22});
            step({crb_pkg::OPC_INC_SKIP, 1'b0, 7'h22});
            chk(pc, p + 13'h000e);
            chk(working_reg, 8'h00);
            step(14'h3fff);
            step({crb_pkg::OPC_INC_SKIP, 1'b1, 7'h22});
            step(14'h3fff);
            step({crb_pkg::OPC_INC_SKIP, 1'b1, 7'h22});
            chk(pc, p + 13'h0011);
            chk(discard, 1'b0);
            step({crb_pkg::OPC_MOVWF, crb_pkg::ADDR_PC_LOW});
            chk(pc, {v[4:0], 8'h00});
            step(14'h3fff);
            step({crb_pkg::OPC_INCF, 1'b1, crb_pkg::ADDR_PC_LOW});
            chk(pc, {v[4:0], 8'h01});
            step(14'h3fff);
        end
        summarize();
    end
endmodule // test_crb_core
bind crb_core crb_core_asserts u_chk (.clk(clk), .resetn(resetn), .instr(instr),
    .instr_valid(instr_valid), .pc(pc), .discard(discard), .working_reg(working_reg),
    .status_reg(status_reg), .pc_high_holding_latch(pc_high_holding_latch),
    .pin_direction_reg(pin_direction_reg));
`default_nettype wire
